// ---- hw/dcts_pkg.sv ----
package dcts_pkg;
  // ------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] DCTS_OFS_DC_TERM = 8'h1A;
  localparam logic [7:0] DCTS_OFS_RSVD = 8'h1B;
  localparam logic [7:0] DCTS_OFS_CURRENT = 8'h1C;
  localparam logic [7:0] DCTS_OFS_VOLTAGE = 8'h1D;
  // ------------------------------------------------------------
  // Field positions and reset values
  // ------------------------------------------------------------
  localparam int DCTS_POS_TERM_V = 6;
  localparam int DCTS_POS_MIN_I = 4;
  localparam int DCTS_POS_LIMIT = 1;
  localparam int DCTS_POS_IMPED = 0;
  localparam logic [1:0] DCTS_RSVD_BITS = 2'h0;
  localparam logic [7:0] DCTS_DC_TERM_RST = 8'h00;
  localparam logic [7:0] DCTS_RSVD_RST = 8'h00;
  localparam logic [7:0] DCTS_MEAS_RST = 8'h00;
  localparam logic [7:0] DCTS_RDATA_IDLE = 8'h00;
  localparam logic [7:0] DCTS_NO_READING = 8'h00;
  // ------------------------------------------------------------
  // Physical figures
  // ------------------------------------------------------------
  localparam logic [11:0] DCTS_TERM_MV_0 = 12'hC1C;
  localparam logic [11:0] DCTS_TERM_MV_1 = 12'hC80;
  localparam logic [11:0] DCTS_TERM_MV_2 = 12'hD16;
  localparam logic [11:0] DCTS_TERM_MV_3 = 12'hDAC;
  localparam logic [4:0] DCTS_MIN_MA_0 = 5'h0A;
  localparam logic [4:0] DCTS_MIN_MA_1 = 5'h0C;
  localparam logic [4:0] DCTS_MIN_MA_2 = 5'h0E;
  localparam logic [4:0] DCTS_MIN_MA_3 = 5'h10;
  localparam logic [6:0] DCTS_LIMIT_MA = 7'h3C;
  localparam logic [6:0] DCTS_NO_LIMIT_MA = 7'h00;
  localparam logic [18:0] DCTS_UA_PER_LSB = 19'h0044C;
  // ------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic [1:0] terminal_voltage_select;
    logic [1:0] min_loop_current_select;
    logic loop_current_limit_en;
    logic dc_impedance_select;
  } dcts_ctrl_t;
  typedef struct packed {
    logic [7:0] loop_current_value;
    logic [7:0] line_voltage_value;
  } dcts_meas_t;
endpackage

// ---- hw/dcts_ctrl_dec.sv ----
`timescale 1ns/1ns
module dcts_ctrl_dec import dcts_pkg::*; (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire dcts_ctrl_t ctrl_in,
  input wire logic [7:0] current_in,
  output logic [11:0] term_mv_out,
  output logic [4:0] min_ma_out,
  output logic [6:0] limit_ma_out,
  output logic [18:0] current_ua_out
);
  typedef struct packed {
    logic [11:0] term_mv;
    logic [4:0] min_ma;
    logic [6:0] limit_ma;
    logic [18:0] current_ua;
  } dcts_dec_st_t;
  dcts_dec_st_t st;
  dcts_dec_st_t next_st;
  always_comb begin
    next_st = st;
    unique case (ctrl_in.terminal_voltage_select)
      2'h0: next_st.term_mv = DCTS_TERM_MV_0;
      2'h1: next_st.term_mv = DCTS_TERM_MV_1;
      2'h2: next_st.term_mv = DCTS_TERM_MV_2;
      2'h3: next_st.term_mv = DCTS_TERM_MV_3;
    endcase
    unique case (ctrl_in.min_loop_current_select)
      2'h0: next_st.min_ma = DCTS_MIN_MA_0;
      2'h1: next_st.min_ma = DCTS_MIN_MA_1;
      2'h2: next_st.min_ma = DCTS_MIN_MA_2;
      2'h3: next_st.min_ma = DCTS_MIN_MA_3;
    endcase
    next_st.limit_ma = ctrl_in.loop_current_limit_en ? DCTS_LIMIT_MA : DCTS_NO_LIMIT_MA;
    next_st.current_ua = 19'({11'h000, current_in} * DCTS_UA_PER_LSB);
  end
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      st <= '{DCTS_TERM_MV_0, DCTS_MIN_MA_0, DCTS_NO_LIMIT_MA, 19'h00000};
    end else begin
      st <= next_st;
    end
  end
  assign term_mv_out = st.term_mv;
  assign min_ma_out = st.min_ma;
  assign limit_ma_out = st.limit_ma;
  assign current_ua_out = st.current_ua;
endmodule

// ---- hw/dcts_meas_cap.sv ----
`timescale 1ns/1ns
module dcts_meas_cap import dcts_pkg::*; (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic valid_in,
  input wire dcts_meas_t meas_in,
  output dcts_meas_t meas_out,
  output logic low_current_out,
  output logic no_line_out,
  output logic reversal_out
);
  typedef struct packed {
    dcts_meas_t meas;
    logic primed;
    logic low_current;
    logic no_line;
    logic reversal;
  } dcts_cap_st_t;
  dcts_cap_st_t st;
  dcts_cap_st_t next_st;
  always_comb begin
    next_st = st;
    next_st.reversal = 1'b0;
    // Sampled whatever the hook state
    if (valid_in) begin
      next_st.meas = meas_in;
      next_st.primed = 1'b1;
      next_st.low_current = (meas_in.loop_current_value == DCTS_NO_READING);
      next_st.no_line = (meas_in.line_voltage_value == DCTS_NO_READING);
      // First sample only arms the detector
      next_st.reversal = st.primed &&
        (meas_in.line_voltage_value[7] != st.meas.line_voltage_value[7]);
    end
  end
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      st <= '{'{DCTS_MEAS_RST, DCTS_MEAS_RST}, 1'b0, 1'b1, 1'b1, 1'b0};
    end else begin
      st <= next_st;
    end
  end
  assign meas_out = st.meas;
  assign low_current_out = st.low_current;
  assign no_line_out = st.no_line;
  assign reversal_out = st.reversal;
endmodule

// ---- hw/dcts_regs.sv ----
// Design decision made here: strobed register access.
`timescale 1ns/1ns
module dcts_regs import dcts_pkg::*; (
  input wire logic MCLK_IN,
  input wire logic NRST_IN,
  input wire logic [7:0] REG_ADDR_IN,
  input wire logic [7:0] REG_WDATA_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  input wire logic MEAS_VALID_IN,
  input wire dcts_meas_t MEAS_IN,
  output logic [7:0] REG_RDATA_OUT,
  output dcts_ctrl_t CTRL_OUT,
  output dcts_meas_t MEAS_OUT,
  output logic [11:0] DC_TERMINATION_PIN_MV_OUT,
  output logic [4:0] MIN_LOOP_CURRENT_MA_OUT,
  output logic [6:0] CURRENT_LIMIT_MA_OUT,
  output logic [18:0] LOOP_CURRENT_UA_OUT,
  output logic LOW_LOOP_CURRENT_OUT,
  output logic NO_LINE_OUT,
  output logic LINE_POLARITY_OUT,
  output logic POLARITY_REVERSAL_OUT
);
  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    dcts_ctrl_t ctrl;
    logic [7:0] rsvd;
    logic [7:0] rdata;
  } dcts_reg_st_t;
  dcts_reg_st_t st;
  dcts_reg_st_t next_st;
  dcts_meas_t meas;
  logic [7:0] term_image;
  logic [7:0] read_value;

  // ------------------------------------------------------------
  // Measurement path and decode
  // ------------------------------------------------------------
  dcts_meas_cap u_cap (
    .clk_in(MCLK_IN),
    .rst_n_in(NRST_IN),
    .valid_in(MEAS_VALID_IN),
    .meas_in(MEAS_IN),
    .meas_out(meas),
    .low_current_out(LOW_LOOP_CURRENT_OUT),
    .no_line_out(NO_LINE_OUT),
    .reversal_out(POLARITY_REVERSAL_OUT)
  );

  dcts_ctrl_dec u_dec (
    .clk_in(MCLK_IN),
    .rst_n_in(NRST_IN),
    .ctrl_in(st.ctrl),
    .current_in(meas.loop_current_value),
    .term_mv_out(DC_TERMINATION_PIN_MV_OUT),
    .min_ma_out(MIN_LOOP_CURRENT_MA_OUT),
    .limit_ma_out(CURRENT_LIMIT_MA_OUT),
    .current_ua_out(LOOP_CURRENT_UA_OUT)
  );

  // ------------------------------------------------------------
  // Read image
  // ------------------------------------------------------------
  always_comb begin
    term_image = {st.ctrl.terminal_voltage_select,
                  st.ctrl.min_loop_current_select,
                  DCTS_RSVD_BITS,
                  st.ctrl.loop_current_limit_en,
                  st.ctrl.dc_impedance_select};
  end

  always_comb begin
    case (REG_ADDR_IN)
      DCTS_OFS_DC_TERM: begin
        read_value = term_image;
      end
      DCTS_OFS_RSVD: begin
        read_value = st.rsvd;
      end
      DCTS_OFS_CURRENT: begin
        read_value = meas.loop_current_value;
      end
      DCTS_OFS_VOLTAGE: begin
        read_value = meas.line_voltage_value;
      end
      default: begin
        read_value = DCTS_RDATA_IDLE;
      end
    endcase
  end

  // ------------------------------------------------------------
  // Register writes and read return
  // ------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.rdata = DCTS_RDATA_IDLE;
    if (REG_WR_IN) begin
      case (REG_ADDR_IN)
        DCTS_OFS_DC_TERM: begin
          next_st.ctrl.terminal_voltage_select =
            REG_WDATA_IN[DCTS_POS_TERM_V +: 2];
          next_st.ctrl.min_loop_current_select =
            REG_WDATA_IN[DCTS_POS_MIN_I +: 2];
          next_st.ctrl.loop_current_limit_en =
            REG_WDATA_IN[DCTS_POS_LIMIT];
          next_st.ctrl.dc_impedance_select =
            REG_WDATA_IN[DCTS_POS_IMPED];
        end
        DCTS_OFS_RSVD: begin
          // Kept only so a stray write reads back
          next_st.rsvd = REG_WDATA_IN;
        end
        default: begin
          // Readings and unmapped addresses drop the write
          next_st.rsvd = st.rsvd;
        end
      endcase
    end
    if (REG_RD_IN) begin
      next_st.rdata = read_value;
    end
  end

  always_ff @(posedge MCLK_IN) begin
    if (!NRST_IN) begin
      st <= '{dcts_ctrl_t'({DCTS_DC_TERM_RST[7:4], DCTS_DC_TERM_RST[1:0]}),
              DCTS_RSVD_RST, DCTS_RDATA_IDLE};
    end else begin
      st <= next_st;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign REG_RDATA_OUT = st.rdata;
  assign CTRL_OUT = st.ctrl;
  assign MEAS_OUT = meas;
  assign LINE_POLARITY_OUT = meas.line_voltage_value[7];

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge MCLK_IN);
  endclocking
  default disable iff (!NRST_IN);

  logic past_rst_done;
  always_ff @(posedge MCLK_IN) begin
    past_rst_done <= NRST_IN;
  end

  sequence s_term_write;
    REG_WR_IN && REG_ADDR_IN == DCTS_OFS_DC_TERM;
  endsequence

  sequence s_term_read;
    REG_RD_IN && REG_ADDR_IN == DCTS_OFS_DC_TERM;
  endsequence

  sequence s_sample(logic [7:0] cur, logic [7:0] volt);
    MEAS_VALID_IN && MEAS_IN.loop_current_value == cur &&
      MEAS_IN.line_voltage_value == volt;
  endsequence

  a_term_v_write: assert property (
    s_term_write |=> CTRL_OUT.terminal_voltage_select == $past(REG_WDATA_IN[7:6])
  ) else $error("terminal voltage field not stored");

  a_term_v_volts: assert property (
    s_term_write and REG_WDATA_IN[7:6] == 2'h2 |-> ##2 DC_TERMINATION_PIN_MV_OUT == 12'hD16
  ) else $error("terminal voltage code 10 not 3.35 V");

  a_min_i_map: assert property (
    s_term_write and REG_WDATA_IN[5:4] == 2'h3 |-> ##2 MIN_LOOP_CURRENT_MA_OUT == 5'h10
  ) else $error("minimum current code 11 not 16 mA");

  a_limit_map: assert property (
    s_term_write |-> ##2
      CURRENT_LIMIT_MA_OUT == ($past(REG_WDATA_IN[1], 2) ? 7'h3C : 7'h00)
  ) else $error("current limit setting wrong");

  a_imped_write: assert property (
    s_term_write |=> CTRL_OUT.dc_impedance_select == $past(REG_WDATA_IN[0])
  ) else $error("impedance select not stored");

  a_term_readback: assert property (
    s_term_write ##1 s_term_read |=>
      REG_RDATA_OUT == ($past(REG_WDATA_IN, 2) & 8'hF3)
  ) else $error("dc termination read back wrong");

  a_ro_write_ignored: assert property (
    REG_WR_IN && !MEAS_VALID_IN &&
      (REG_ADDR_IN == DCTS_OFS_CURRENT || REG_ADDR_IN == DCTS_OFS_VOLTAGE)
      |=> $stable(MEAS_OUT)
  ) else $error("reading changed by a write");

  a_cur_read: assert property (
    s_sample(8'h2A, 8'h30) ##1 REG_RD_IN && REG_ADDR_IN == DCTS_OFS_CURRENT
      |=> REG_RDATA_OUT == 8'h2A
  ) else $error("loop current read wrong");

  a_cur_scale: assert property (
    MEAS_VALID_IN |-> ##2 LOOP_CURRENT_UA_OUT ==
      19'({11'h000, $past(MEAS_IN.loop_current_value, 2)} * 19'd1100)
  ) else $error("loop current scale wrong");

  a_volt_read: assert property (
    MEAS_VALID_IN ##1 REG_RD_IN && REG_ADDR_IN == DCTS_OFS_VOLTAGE
      |=> REG_RDATA_OUT == $past(MEAS_IN.line_voltage_value, 2)
  ) else $error("line voltage read wrong");

  a_volt_sign: assert property (
    MEAS_VALID_IN && $signed(MEAS_IN.line_voltage_value) < 0 |=> LINE_POLARITY_OUT
  ) else $error("negative voltage not shown as reversed");

  a_reversal_pulse: assert property (
    MEAS_VALID_IN ##1 MEAS_VALID_IN &&
      MEAS_IN.line_voltage_value[7] != LINE_POLARITY_OUT
      |=> POLARITY_REVERSAL_OUT ##1 (!POLARITY_REVERSAL_OUT || $past(MEAS_VALID_IN))
  ) else $error("polarity reversal not flagged");

  a_no_false_reversal: assert property (
    POLARITY_REVERSAL_OUT |-> $changed(LINE_POLARITY_OUT)
  ) else $error("reversal flagged without polarity change");

  a_low_current: assert property (
    MEAS_VALID_IN |=>
      LOW_LOOP_CURRENT_OUT == ($past(MEAS_IN.loop_current_value) == 8'h00)
  ) else $error("zero current not flagged low");

  a_no_line: assert property (
    MEAS_VALID_IN |=> NO_LINE_OUT == ($past(MEAS_IN.line_voltage_value) == 8'h00)
  ) else $error("no-line flag wrong");

  a_meas_update: assert property (
    MEAS_VALID_IN |=> MEAS_OUT == $past(MEAS_IN)
  ) else $error("measurement not refreshed");

  a_reset_reading: assert property (
    past_rst_done && $rose(past_rst_done) |-> MEAS_OUT.loop_current_value == 8'h00
  ) else $error("loop current not zero after reset");

  a_rdata_one_cycle: assert property (
    !REG_RD_IN |=> REG_RDATA_OUT == 8'h00
  ) else $error("read data held past its cycle");

  // ------------------------------------------------------------
  // Mapping, holding and idle checks
  // ------------------------------------------------------------
  a_min_i_low: assert property (
    s_term_write and REG_WDATA_IN[5:4] == 2'h0 |-> ##2 MIN_LOOP_CURRENT_MA_OUT == 5'h0A
  ) else $error("minimum current code 00 not 10 mA");

  a_ctrl_hold: assert property (
    !REG_WR_IN |=> $stable(CTRL_OUT)
  ) else $error("control fields changed without a write");

  a_meas_hold: assert property (
    !MEAS_VALID_IN |=> $stable(MEAS_OUT)
  ) else $error("reading changed without a sample");

  a_reversal_idle: assert property (
    !MEAS_VALID_IN |=> !POLARITY_REVERSAL_OUT
  ) else $error("reversal flagged without a sample");

  a_rsvd_bits_zero: assert property (
    s_term_read |=> REG_RDATA_OUT[3:2] == 2'h0
  ) else $error("reserved bits read back non-zero");

  a_unmapped_read: assert property (
    REG_RD_IN && (REG_ADDR_IN < DCTS_OFS_DC_TERM || REG_ADDR_IN > DCTS_OFS_VOLTAGE)
      |=> REG_RDATA_OUT == 8'h00
  ) else $error("unmapped read not zero");

endmodule

// ---- verification/dcts_line_model.sv ----
`timescale 1ns/1ns
module dcts_line_model import dcts_pkg::*; (
  input wire logic clk_in,
  output logic valid_out,
  output dcts_meas_t meas_out
);
  // ------------------------------------------------------------
  // Line-side sample source
  // ------------------------------------------------------------
  initial begin
    valid_out = 1'b0;
    meas_out = 16'h5A5A;
  end

  // Samples go out whatever the hook state
  // Voltage code is passed as two's complement, sign gives polarity
  task automatic send(input logic [7:0] cur, input logic [7:0] volt, input int gap);
    repeat (gap) @(posedge clk_in);
    valid_out <= 1'b1;
    meas_out <= {cur, volt};
    @(posedge clk_in);
    valid_out <= 1'b0;
    // Data no longer held once the strobe drops
    meas_out <= ~{cur, volt};
  endtask

  // Two samples on consecutive edges
  task automatic send_pair(input logic [15:0] s0, input logic [15:0] s1);
    valid_out <= 1'b1;
    meas_out <= s0;
    @(posedge clk_in);
    meas_out <= s1;
    @(posedge clk_in);
    valid_out <= 1'b0;
    meas_out <= ~s1;
  endtask
endmodule

// ---- verification/tb_dcts_regs.sv ----
`timescale 1ns/1ns
module tb_dcts_regs import dcts_pkg::*;;
  logic mclk, nrst, reg_wr, reg_rd, meas_valid;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
  dcts_meas_t meas_in, meas_out;
  dcts_ctrl_t ctrl_out;
  logic [11:0] term_mv;
  logic [4:0] min_ma;
  logic [6:0] limit_ma;
  logic [18:0] loop_ua;
  logic low_i, no_line, polarity, reversal, prev_pol, armed;
  int failures, samples_checked;
  logic [11:0] mv_tab [4] = '{12'hC1C, 12'hC80, 12'hD16, 12'hDAC};
  logic [4:0] ma_tab [4] = '{5'h0A, 5'h0C, 5'h0E, 5'h10};

  dcts_regs dut_u (
    .MCLK_IN(mclk), .NRST_IN(nrst), .REG_ADDR_IN(reg_addr), .REG_WDATA_IN(reg_wdata),
    .REG_WR_IN(reg_wr), .REG_RD_IN(reg_rd), .MEAS_VALID_IN(meas_valid), .MEAS_IN(meas_in),
    .REG_RDATA_OUT(reg_rdata), .CTRL_OUT(ctrl_out), .MEAS_OUT(meas_out),
    .DC_TERMINATION_PIN_MV_OUT(term_mv), .MIN_LOOP_CURRENT_MA_OUT(min_ma),
    .CURRENT_LIMIT_MA_OUT(limit_ma), .LOOP_CURRENT_UA_OUT(loop_ua),
    .LOW_LOOP_CURRENT_OUT(low_i), .NO_LINE_OUT(no_line), .LINE_POLARITY_OUT(polarity),
    .POLARITY_REVERSAL_OUT(reversal)
  );

  dcts_line_model line_u (.clk_in(mclk), .valid_out(meas_valid), .meas_out(meas_in));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] dat);
    reg_addr <= a;
    reg_wdata <= dat;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  // Data one cycle only, idle value after
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    chk(32'(reg_rdata), 32'(exp));
    @(negedge mclk);
    chk(32'(reg_rdata), 32'h0);
    @(posedge mclk);
  endtask

  task automatic do_reset();
    nrst <= 1'b0;
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    armed = 1'b0;
    @(negedge mclk);
    chk(32'({ctrl_out, meas_out}), 32'h0);
    chk(32'({term_mv, min_ma, limit_ma}), 32'({12'hC1C, 5'h0A, 7'h00}));
    chk(32'({loop_ua, low_i, no_line, polarity, reversal, reg_rdata}), 32'h00000C00);
    @(posedge mclk);
  endtask

  task automatic meas(input logic [7:0] cur, input logic [7:0] volt, input int gap);
    logic rev;
    rev = armed && (volt[7] !== prev_pol);
    line_u.send(cur, volt, gap);
    @(negedge mclk);
    chk(32'(meas_out), 32'({cur, volt}));
    chk(32'({low_i, no_line, polarity, reversal}),
        32'({cur == 8'h00, volt == 8'h00, volt[7], rev}));
    @(negedge mclk);
    chk(32'({loop_ua, reversal}), 32'({19'(cur) * 19'h0044C, 1'b0}));
    armed = 1'b1;
    prev_pol = volt[7];
    @(posedge mclk);
  endtask

  // Back-to-back samples with a read in the second sample's cycle
  task automatic pair(input logic [15:0] s0, input logic [15:0] s1, input logic [7:0] a,
                      input logic [7:0] exp);
    fork
      begin
        line_u.send_pair(s0, s1);
        @(negedge mclk);
        chk(32'(meas_out), 32'(s1));
        chk(32'({polarity, reversal}), 32'({s1[7], s1[7] != s0[7]}));
      end
      begin
        @(posedge mclk);
        rd(a, exp);
      end
    join
    prev_pol = s1[7];
  endtask

  task automatic end_sim();
    $display("checks=%0d failures=%0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // Clock and watchdog
  // ------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  initial begin
    repeat (2000) @(posedge mclk);
    failures++;
    end_sim();
  end

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    failures = 0;
    samples_checked = 0;
    prev_pol = 1'b0;
    do_reset();
    rd(DCTS_OFS_CURRENT, 8'h00);
    rd(DCTS_OFS_VOLTAGE, 8'h00);
    rd(8'h40, 8'h00);
    for (int i = 0; i < 16; i++) begin
      // Reserved bits 3:2 left zero
      d = {i[3:0], 2'b00, i[0], i[2]};
      wr(DCTS_OFS_DC_TERM, d);
      rd(DCTS_OFS_DC_TERM, d);
      @(negedge mclk);
      chk(32'(ctrl_out), 32'({d[7:4], d[1:0]}));
      chk(32'({term_mv, min_ma, limit_ma}),
          32'({mv_tab[i[3:2]], ma_tab[i[1:0]], i[0] ? 7'h3C : 7'h00}));
      @(posedge mclk);
    end
    // Reserved register 0x1B is never written
    wr(DCTS_OFS_DC_TERM, 8'h80);
    @(posedge mclk);
    @(negedge mclk);
    chk(32'({term_mv, min_ma}), 32'({12'hD16, 5'h0A}));
    @(posedge mclk);
    meas(8'h00, 8'h00, 0);
    meas(8'h2D, 8'h30, 0);
    meas(8'hFF, 8'hD0, 0);
    meas(8'h12, 8'hC8, 3);
    meas(8'h12, 8'h31, 1);
    wr(DCTS_OFS_CURRENT, 8'hFF);
    @(posedge mclk);
    wr(DCTS_OFS_VOLTAGE, 8'h00);
    rd(DCTS_OFS_CURRENT, 8'h12);
    rd(DCTS_OFS_VOLTAGE, 8'h31);
    do_reset();
    meas(8'h01, 8'h80, 0);
    rd(DCTS_OFS_VOLTAGE, 8'h80);
    pair(16'h2A30, 16'h1BD0, DCTS_OFS_CURRENT, 8'h2A);
    pair(16'h0520, 16'h06E0, DCTS_OFS_VOLTAGE, 8'h20);
    end_sim();
  end
endmodule
